// ==== design/ddrb_core.sv ====
/*
  dram command sequencer, core clock side: bank state, power-down and self refresh
  tracking, refresh busy time, burst column ordering and auto precharge timing.
  assumes the controller keeps its own timing; this block follows the command stream
  and does not police it. commands arrive from ddrb_link_rx on the link clock.
*/
`timescale 1ns/1ps
// Contract
// - power-down with all banks idle is precharge type, with a row open active type.
// - data and strobe outputs stay high-impedance during refresh.
// - bursts start at the addressed column and continue in programmed order.
// - auto precharge closes the bank only once row active time has elapsed.
// - deselect and no-op are treated identically.
module ddrb_core
  import ddrb_pkg::*;
#(
  parameter int BANKS = NUM_BANKS
)
(
  // core clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link clock and command pins
  input wire logic link_ck,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  // burst mode
  input wire ddrb_blen_t burst_len,
  input wire logic burst_interleave,
  // status
  output ddrb_status_t status,
  // burst beats
  output logic beat_valid,
  output logic beat_write,
  output logic [BA_W-1:0] beat_bank,
  output logic [COL_W-1:0] beat_col,
  // data pin enables
  output logic dq_oe,
  output logic dqs_oe
);

  // the bank field of a command must reach every bank and no more
  if (BANKS != (1 << BA_W)) begin : g_bad_banks
    $error("BANKS must equal two to the power of the bank address width");
  end

  // ************************************************************
  // link capture and crossing
  // ************************************************************
  ddrb_cmd_t link_word;
  logic link_tog;

  ddrb_link_rx u_link_rx (
    .link_ck(link_ck),
    .rst_n(rst_n),
    .cke(cke),
    .cs_n(cs_n),
    .ras_n(ras_n),
    .cas_n(cas_n),
    .we_n(we_n),
    .ba(ba),
    .addr(addr),
    .cmd_word(link_word),
    .cmd_toggle(link_tog)
  );

  logic tog_meta_reg;
  logic tog_sync_reg;
  logic tog_seen_reg;

  always_ff @(posedge clk) begin
    tog_meta_reg <= link_tog;
    tog_sync_reg <= tog_meta_reg;
    tog_seen_reg <= rst_n ? tog_sync_reg : 1'b0;
  end

  // the word was written a full sync delay before the toggle is seen here and is held
  // for a link period, so it is stable when taken
  logic ev;
  assign ev = tog_sync_reg ^ tog_seen_reg;

  // ************************************************************
  // burst column ordering
  // ************************************************************
  function automatic logic [COL_W-1:0] order_col(input logic [COL_W-1:0] start, input logic [BEAT_W-1:0] idx,
                                                 input ddrb_blen_t len, input logic ilv);
    logic [COL_W-1:0] mask;
    logic [COL_W-1:0] off;
    mask = (COL_W'(1) << len) - COL_W'(1);
    off = ilv ? ((start ^ COL_W'(idx)) & mask) : ((start + COL_W'(idx)) & mask);
    return (start & ~mask) | off; // first beat is the addressed column
  endfunction

  // ************************************************************
  // state
  // ************************************************************
  ddrb_pwr_t pwr_reg, pwr_next;
  logic [BANKS-1:0] open_reg, open_next;
  logic [BANKS-1:0] ap_reg, ap_next;
  logic [CNT_W-1:0] ras_cnt_reg [BANKS];
  logic [CNT_W-1:0] ras_cnt_next [BANKS];
  logic [CNT_W-1:0] rfc_cnt_reg, rfc_cnt_next;
  logic prev_cke_reg, prev_cke_next;
  logic [BEAT_W:0] left_reg, left_next;
  logic [BEAT_W-1:0] idx_reg, idx_next;
  logic [COL_W-1:0] start_reg, start_next;
  logic burst_ap_reg, burst_ap_next;
  logic wr_reg, wr_next;
  logic [BA_W-1:0] bank_reg, bank_next;
  logic beat_valid_reg, beat_valid_next;
  logic [COL_W-1:0] beat_col_reg, beat_col_next;
  logic dq_oe_reg, dq_oe_next;

  always_comb begin
    logic [BANKS-1:0] after_cmd;
    after_cmd = open_reg;
    pwr_next = pwr_reg;
    open_next = open_reg;
    ap_next = ap_reg;
    rfc_cnt_next = (rfc_cnt_reg != '0) ? rfc_cnt_reg - CNT_W'(1) : rfc_cnt_reg;
    prev_cke_next = prev_cke_reg;
    left_next = left_reg;
    idx_next = idx_reg;
    start_next = start_reg;
    burst_ap_next = burst_ap_reg;
    wr_next = wr_reg;
    bank_next = bank_reg;
    beat_valid_next = 1'b0;
    beat_col_next = beat_col_reg;

    // per-bank row active timers and auto precharge
    for (int b = 0; b < BANKS; b++) begin
      ras_cnt_next[b] = (ras_cnt_reg[b] != '0) ? ras_cnt_reg[b] - CNT_W'(1) : ras_cnt_reg[b];
      if (ap_reg[b] && ras_cnt_reg[b] == '0) begin
        open_next[b] = 1'b0; // internal precharge waits for row active time
        ap_next[b] = 1'b0;
      end
    end

    // burst beats
    if (left_reg != '0) begin
      beat_valid_next = 1'b1;
      beat_col_next = order_col(start_reg, idx_reg, burst_len, burst_interleave);
      idx_next = idx_reg + BEAT_W'(1);
      left_next = left_reg - (BEAT_W + 1)'(1);
      if (left_reg == (BEAT_W + 1)'(1) && burst_ap_reg) begin
        ap_next[bank_reg] = 1'b1;
      end
    end

    if (ev) begin
      prev_cke_next = link_word.cke;
      // bank effect of the command itself, applied before any power-down decision
      if (link_word.cke) begin
        case (link_word.kind)
          CMD_ACT: begin
            after_cmd[link_word.ba] = 1'b1;
            ras_cnt_next[link_word.ba] = ROW_ACTIVE_CYC;
          end
          CMD_PRE: begin
            if (link_word.addr[PRECHARGE_ALL_ADDRESS_BIT]) begin
              after_cmd = '0; // bank address ignored
            end else begin
              after_cmd[link_word.ba] = 1'b0;
            end
          end
          CMD_READ, CMD_WRITE: begin
            start_next = link_word.addr[COL_W-1:0];
            idx_next = '0;
            left_next = (BEAT_W + 1)'(1) << burst_len;
            burst_ap_next = link_word.addr[PRECHARGE_ALL_ADDRESS_BIT];
            wr_next = (link_word.kind == CMD_WRITE);
            bank_next = link_word.ba;
          end
          CMD_BST: left_next = '0;
          default: ;
        endcase
      end
      open_next = (open_next & after_cmd) | (after_cmd & ~open_reg);

      case (pwr_reg)
        PWR_RUN: begin
          if (link_word.kind == CMD_REFRESH && link_word.cke && prev_cke_reg) begin
            rfc_cnt_next = REFRESH_CYC; // controller keeps clock enable high
          end else if (!link_word.cke && prev_cke_reg) begin
            if (link_word.kind == CMD_REFRESH) begin
              pwr_next = PWR_SELF_REF; // banks already idle
            end else if (open_next != '0) begin
              pwr_next = PWR_ACT_PD;
            end else begin
              pwr_next = PWR_PRE_PD;
            end
          end
        end
        default: begin
          if (link_word.cke) begin
            pwr_next = PWR_RUN;
          end
        end
      endcase
    end

    // self refresh runs the refresh internally, so outputs stay off there too
    dq_oe_next = beat_valid_next && !wr_next && rfc_cnt_next == '0 && pwr_next != PWR_SELF_REF;

    if (!rst_n) begin
      pwr_next = PWR_RUN;
      open_next = '0;
      ap_next = '0;
      rfc_cnt_next = '0;
      prev_cke_next = 1'b1;
      left_next = '0;
      idx_next = '0;
      start_next = '0;
      burst_ap_next = 1'b0;
      wr_next = 1'b0;
      bank_next = '0;
      beat_valid_next = 1'b0;
      beat_col_next = '0;
      dq_oe_next = 1'b0;
      for (int b = 0; b < BANKS; b++) begin
        ras_cnt_next[b] = '0;
      end
    end
  end

  always_ff @(posedge clk) begin
    pwr_reg <= pwr_next;
    open_reg <= open_next;
    ap_reg <= ap_next;
    rfc_cnt_reg <= rfc_cnt_next;
    prev_cke_reg <= prev_cke_next;
    left_reg <= left_next;
    idx_reg <= idx_next;
    start_reg <= start_next;
    burst_ap_reg <= burst_ap_next;
    wr_reg <= wr_next;
    bank_reg <= bank_next;
    beat_valid_reg <= beat_valid_next;
    beat_col_reg <= beat_col_next;
    dq_oe_reg <= dq_oe_next;
    for (int b = 0; b < BANKS; b++) begin
      ras_cnt_reg[b] <= ras_cnt_next[b];
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign status = '{pwr: pwr_reg, bank_open: open_reg, refresh_busy: (rfc_cnt_reg != '0)};
  assign beat_valid = beat_valid_reg;
  assign beat_write = wr_reg;
  assign beat_bank = bank_reg;
  assign beat_col = beat_col_reg;
  assign dq_oe = dq_oe_reg;
  assign dqs_oe = dq_oe_reg; // strobe travels with read data only

endmodule // ddrb_core

// ==== design/ddrb_link_rx.sv ====
/*
  link side of the sequencer: samples the command pins on each rising link clock edge,
  decodes them and hands every sampled word to the core by a toggle.
  assumes the pins change with the link clock and that the core clock is much faster,
  so a word stays stable long enough to be taken after the toggle is synchronised.
*/
`timescale 1ns/1ps
module ddrb_link_rx
  import ddrb_pkg::*;
(
  // link clock and core reset
  input wire logic link_ck,
  input wire logic rst_n,
  // command pins
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BA_W-1:0] ba,
  input wire logic [ADDR_W-1:0] addr,
  // toward the core
  output ddrb_cmd_t cmd_word,
  output logic cmd_toggle
);

  // ************************************************************
  // reset brought into the link domain
  // ************************************************************
  logic rst_meta_reg;
  logic rst_sync_n_reg;

  always_ff @(posedge link_ck) begin
    rst_meta_reg <= rst_n;
    rst_sync_n_reg <= rst_meta_reg;
  end

  // ************************************************************
  // decode
  // ************************************************************
  ddrb_cmd_t word_reg;
  ddrb_cmd_t word_next;
  logic tog_reg;
  logic tog_next;

  always_comb begin
    word_next.cke = cke;
    word_next.ba = ba;
    word_next.addr = addr;
    if (cs_n) begin
      word_next.kind = CMD_NOP; // deselect is a no-op
    end else begin
      case ({ras_n, cas_n, we_n})
        3'h3: word_next.kind = CMD_ACT;
        3'h5: word_next.kind = CMD_READ;
        3'h4: word_next.kind = CMD_WRITE;
        3'h2: word_next.kind = CMD_PRE;
        3'h1: word_next.kind = CMD_REFRESH;
        3'h0: word_next.kind = CMD_LMR;
        3'h6: word_next.kind = CMD_BST;
        default: word_next.kind = CMD_NOP;
      endcase
    end
    tog_next = ~tog_reg;
    if (!rst_sync_n_reg) begin
      word_next = CMD_IDLE_WORD;
      tog_next = 1'b0;
    end
  end

  always_ff @(posedge link_ck) begin
    word_reg <= word_next;
    tog_reg <= tog_next;
  end

  assign cmd_word = word_reg;
  assign cmd_toggle = tog_reg;

endmodule // ddrb_link_rx

// ==== design/ddrb_pkg.sv ====
/*
  shared constants and types for the dram command sequencer: command kinds,
  the command word that crosses from the link clock, power states and timing counts.
  assumes a 200 MHz core clock; timing figures are plain defaults, not taken from any part.
*/
package ddrb_pkg;

  // ************************************************************
  // geometry
  // ************************************************************
  localparam int BA_W = 2;
  localparam int NUM_BANKS = 4;
  localparam int ADDR_W = 13;
  localparam int COL_W = 10;
  localparam int PRECHARGE_ALL_ADDRESS_BIT = 10;
  localparam int BEAT_W = 3;

  // ************************************************************
  // timing, figures in ns and the clock period in ps, counts rounded up to whole core cycles
  // ************************************************************
  localparam int CLK_PERIOD_PS = 5000;
  localparam int ROW_ACTIVE_TIME_NS = 40;
  localparam int REFRESH_CYCLE_TIME_NS = 75;
  localparam int CNT_W = 8;
  localparam int ROW_ACTIVE_CYC_I = (ROW_ACTIVE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int REFRESH_CYC_I = (REFRESH_CYCLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [CNT_W-1:0] ROW_ACTIVE_CYC = CNT_W'(ROW_ACTIVE_CYC_I);
  localparam logic [CNT_W-1:0] REFRESH_CYC = CNT_W'(REFRESH_CYC_I);

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_REFRESH, CMD_LMR, CMD_BST
  } ddrb_cmd_kind_t;

  // burst length as log2: 2, 4 or 8 beats
  typedef enum logic [1:0] {BL_2 = 2'h1, BL_4 = 2'h2, BL_8 = 2'h3} ddrb_blen_t;

  typedef enum logic [1:0] {PWR_RUN, PWR_PRE_PD, PWR_ACT_PD, PWR_SELF_REF} ddrb_pwr_t;

  typedef struct packed {
    logic cke;
    ddrb_cmd_kind_t kind;
    logic [BA_W-1:0] ba;
    logic [ADDR_W-1:0] addr;
  } ddrb_cmd_t;

  typedef struct packed {
    ddrb_pwr_t pwr;
    logic [NUM_BANKS-1:0] bank_open;
    logic refresh_busy;
  } ddrb_status_t;

  localparam ddrb_cmd_t CMD_IDLE_WORD = '{cke: 1'b1, kind: CMD_NOP, ba: '0, addr: '0};

endpackage

// ==== test/ddrb_core_assertions.sv ====
/*
  checker for ddrb_core: power state, refresh busy time, burst order and data pin enables.
  assumes it is bound to ddrb_core and sees only its ports.
*/
`timescale 1ns/1ps
module ddrb_core_chk
  import ddrb_pkg::*;
#(
  parameter int BANKS = NUM_BANKS
)
(
  // core clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // burst mode
  input wire ddrb_blen_t burst_len,
  input wire logic burst_interleave,
  // observed outputs
  input wire ddrb_status_t status,
  input wire logic beat_valid,
  input wire logic beat_write,
  input wire logic [COL_W-1:0] beat_col,
  input wire logic dq_oe,
  input wire logic dqs_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [COL_W-1:0] blk_mask;
  assign blk_mask = (COL_W'(1) << burst_len) - COL_W'(1);

  no_drive_ref_a:
    assert property (status.refresh_busy |-> !dq_oe && !dqs_oe) else $error("data driven in refresh");
  no_drive_sr_a:
    assert property (status.pwr == PWR_SELF_REF |-> !(dq_oe || dqs_oe)) else $error("data driven in self refresh");
  oe_read_a:
    assert property (dq_oe == (beat_valid && !beat_write) && dqs_oe == dq_oe) else $error("enable off a read beat");
  pre_pd_a:
    assert property ($changed(status.pwr) && status.pwr == PWR_PRE_PD |-> status.bank_open == '0)
      else $error("precharge power-down with a row open");
  act_pd_a:
    assert property ($changed(status.pwr) && status.pwr == PWR_ACT_PD |-> status.bank_open != '0)
      else $error("active power-down with all banks idle");
  seq_order_a:
    assert property (beat_valid && $past(beat_valid) && !burst_interleave |->
      (beat_col & blk_mask) == (($past(beat_col) + COL_W'(1)) & blk_mask) &&
      (beat_col & ~blk_mask) == ($past(beat_col) & ~blk_mask)) else $error("sequential beat order broken");
  refresh_time_a:
    assert property ($rose(status.refresh_busy) |-> status.refresh_busy [*8] ##1 status.refresh_busy [*7]
      ##1 !status.refresh_busy) else $error("refresh busy not 15 cycles");
  sr_idle_a:
    assert property (status.pwr == PWR_SELF_REF |-> status.bank_open == '0) else $error("row open in self refresh");
  // a bank closed too early by auto precharge would cut the row short
  for (genvar i = 0; i < BANKS; i++) begin : g_row
    row_time_a:
      assert property ($rose(status.bank_open[i]) |-> status.bank_open[i] [*8]) else $error("row closed too early");
  end
endmodule // ddrb_core_chk

bind ddrb_core ddrb_core_chk #(.BANKS(BANKS)) ddrb_core_chk_inst (.clk(clk), .rst_n(rst_n), .burst_len(burst_len),
  .burst_interleave(burst_interleave), .status(status), .beat_valid(beat_valid), .beat_write(beat_write),
  .beat_col(beat_col), .dq_oe(dq_oe), .dqs_oe(dqs_oe));

// ==== test/ddrb_ctrl_model.sv ====
/*
  behavioural dram controller: one command on a link clock edge, then deselect edges.
  assumes link_ck comes from the bench and runs free; the caller keeps command spacing.
*/
`timescale 1ns/1ps
module ddrb_ctrl_model
  import ddrb_pkg::*;
(
  // link clock
  input wire logic link_ck,
  // command pins
  output logic cke,
  output logic cs_n,
  output logic ras_n,
  output logic cas_n,
  output logic we_n,
  output logic [BA_W-1:0] ba,
  output logic [ADDR_W-1:0] addr
);
  // ras_n, cas_n, we_n for each command kind
  localparam logic [2:0] ENC [8] = '{3'h7, 3'h3, 3'h5, 3'h4, 3'h2, 3'h1, 3'h0, 3'h6};
  // no strobe pin reaches the block, so the write strobe preamble is this side's alone

  initial begin
    cke = 1'b1;
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = 3'h7;
    ba = '0;
    addr = '0;
  end

  task automatic send(input ddrb_cmd_kind_t k, input logic [BA_W-1:0] b, input logic [ADDR_W-1:0] a, input logic ck);
    @(posedge link_ck);
    #1;
    cke = ck; // level held until the next call, so high through refresh
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = ENC[k];
    ba = b;
    addr = a;
    @(posedge link_ck);
    #1;
    cs_n = 1'b1; // deselect edges only until the next call
    // released lines must not keep showing the old command
    {ras_n, cas_n, we_n} = ~ENC[k];
    ba = ~b;
    addr = ~a;
    @(posedge link_ck);
    #1;
  endtask
endmodule // ddrb_ctrl_model

// ==== test/testbench.sv ====
/*
  self-checking bench for ddrb_core: bursts, power-down, refresh and self refresh.
  assumes ddrb_ctrl_model drives the command pins on an 80 ns link clock.
*/
`timescale 1ns/1ps
module testbench
  import ddrb_pkg::*;
;
  logic clk, link_ck, rst_n, cke, cs_n, ras_n, cas_n, we_n, burst_interleave, beat_valid, beat_write, dq_oe, dqs_oe;
  logic [BA_W-1:0] ba, beat_bank;
  logic [ADDR_W-1:0] addr;
  logic [COL_W-1:0] beat_col;
  ddrb_blen_t burst_len;
  ddrb_status_t status;
  int mismatches, n_compared;
  logic [15:0] got [$];

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // odd start offset keeps the two clocks out of phase
  initial begin
    link_ck = 1'b0;
    #3.3;
    forever #40 link_ck = ~link_ck;
  end

  ddrb_core ddrb_core_inst (.clk(clk), .rst_n(rst_n), .link_ck(link_ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .burst_len(burst_len), .burst_interleave(burst_interleave),
    .status(status), .beat_valid(beat_valid), .beat_write(beat_write), .beat_bank(beat_bank), .beat_col(beat_col),
    .dq_oe(dq_oe), .dqs_oe(dqs_oe));
  ddrb_ctrl_model ddrb_ctrl_model_inst (.link_ck(link_ck), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
    .we_n(we_n), .ba(ba), .addr(addr));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic cmd(input ddrb_cmd_kind_t k, input logic [1:0] b, input logic [12:0] a, input logic ck);
    ddrb_ctrl_model_inst.send(k, b, a, ck);
  endtask

  // beats are sampled on the falling edge, where registered outputs have settled
  task automatic collect(input int n);
    got.delete();
    repeat (n) begin
      @(negedge clk);
      if (beat_valid === 1'b1) got.push_back({dq_oe, dqs_oe, beat_write, beat_bank, 1'b0, beat_col});
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_burst(input ddrb_cmd_kind_t k, input logic [1:0] b, input logic [9:0] col, input ddrb_blen_t bl,
                         input logic ilv, input logic ap);
    logic [9:0] m, c;
    @(posedge clk);
    #1;
    burst_len = bl;
    burst_interleave = ilv;
    m = (10'h1 << bl) - 10'h1;
    cmd(CMD_ACT, b, 13'h0123, 1'b1);
    fork
      cmd(k, b, {2'h0, ap, col}, 1'b1);
      collect(56);
    join
    check(16'(got.size()), 16'h1 << bl);
    foreach (got[i]) begin
      c = ilv ? (col ^ 10'(i)) : ((col & ~m) | ((col + 10'(i)) & m));
      check(got[i], {{2{k == CMD_READ}}, k == CMD_WRITE, b, 1'b0, c});
    end
    check(16'(status.bank_open[b]), 16'(!ap));
    if (!ap) cmd(CMD_PRE, b, 13'h0, 1'b1);
    check(16'(status.bank_open), 16'h0);
    $display("burst test done");
  endtask

  task automatic t_power();
    cmd(CMD_NOP, 2'h0, 13'h0, 1'b0);
    check(16'(status.pwr), 16'(PWR_PRE_PD));
    cmd(CMD_NOP, 2'h0, 13'h0, 1'b1);
    check(16'(status.pwr), 16'(PWR_RUN));
    cmd(CMD_ACT, 2'h0, 13'h0, 1'b1);
    cmd(CMD_ACT, 2'h3, 13'h0, 1'b1);
    cmd(CMD_NOP, 2'h0, 13'h0, 1'b0); // no burst in progress
    check(16'(status.pwr), 16'(PWR_ACT_PD));
    check(16'(status.bank_open), 16'h9);
    cmd(CMD_NOP, 2'h0, 13'h0, 1'b1);
    cmd(CMD_PRE, 2'h1, 13'h0400, 1'b1); // two rows open, so precharge all
    check(16'(status.bank_open), 16'h0);
    cmd(CMD_NOP, 2'h0, 13'h0, 1'b0);
    check(16'(status.pwr), 16'(PWR_PRE_PD));
    cmd(CMD_NOP, 2'h0, 13'h0, 1'b1);
    // mode load leaves the delay-locked loop alone, so reads need no extra wait
    cmd(CMD_LMR, 2'h0, 13'h0, 1'b1);
    cmd(CMD_BST, 2'h0, 13'h0, 1'b1); // stop with no burst running changes nothing
    check(16'(status), 16'h0);
    $display("power-down test done");
  endtask

  task automatic t_refresh();
    int n;
    n = 0;
    fork
      cmd(CMD_REFRESH, 2'h0, 13'h0, 1'b1);
      repeat (60) begin
        @(negedge clk);
        if (status.refresh_busy === 1'b1) begin
          n++;
          check(16'({dq_oe, dqs_oe}), 16'h0);
        end
      end
    join
    check(16'(n), 16'(REFRESH_CYC));
    cmd(CMD_REFRESH, 2'h0, 13'h0, 1'b0); // all banks idle on entry
    check(16'(status.pwr), 16'(PWR_SELF_REF));
    check(16'({dq_oe, dqs_oe}), 16'h0);
    cmd(CMD_NOP, 2'h0, 13'h0, 1'b1); // link clock never stops
    check(16'(status.pwr), 16'(PWR_RUN));
    repeat (200) @(posedge link_ck); // exit delays before any read
    cmd(CMD_REFRESH, 2'h0, 13'h0, 1'b1); // refresh on return to normal work
    check(16'(status), 16'h1); // busy still counting one link period later
    // self refresh is not entered again and the link clock never changes rate
    $display("refresh test done");
  endtask

  initial begin
    #200us;
    mismatches++;
    end_sim();
  end

  initial begin
    rst_n = 1'b0;
    burst_len = BL_4;
    burst_interleave = 1'b0;
    // held long enough for the link side to see it as well
    repeat (5) @(posedge link_ck);
    @(posedge clk);
    #1;
    rst_n = 1'b1;
    @(negedge clk);
    check(16'(status), 16'h0);
    check(16'({beat_valid, dq_oe, dqs_oe}), 16'h0);
    repeat (2) @(posedge link_ck);
    t_burst(CMD_READ, 2'h1, 10'h005, BL_4, 1'b0, 1'b1);
    t_burst(CMD_WRITE, 2'h2, 10'h00B, BL_8, 1'b1, 1'b0);
    t_burst(CMD_READ, 2'h3, 10'h3FF, BL_2, 1'b0, 1'b0);
    t_burst(CMD_WRITE, 2'h0, 10'h012, BL_4, 1'b1, 1'b1);
    t_power();
    t_refresh();
    t_burst(CMD_READ, 2'h2, 10'h0F6, BL_8, 1'b0, 1'b1);
    end_sim();
  end
endmodule // testbench
